// ---- hw/twb_if.sv ----
// open-drain two-wire bus joining the master end and the slave end
// each party only pulls low; the pull-up is modelled by the nor below
`timescale 1ns/100ps
interface twb_if;
  logic m_scl_oe;
  logic m_sda_oe;
  logic s_scl_oe;
  logic s_sda_oe;
  logic scl;
  logic sda;
  assign scl = ~(m_scl_oe | s_scl_oe);
  assign sda = ~(m_sda_oe | s_sda_oe);
  modport master (output m_scl_oe, output m_sda_oe, input scl, input sda);
  modport slave (output s_scl_oe, output s_sda_oe, input scl, input sda);
endinterface : twb_if

// ---- hw/twb_master.sv ----
// device end: two-wire bus master with byte-level command port
// bus pins come from another domain and are synchronised here
`timescale 1ns/100ps
`include "twb_params.svh"
module twb_master (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic serial_power_gate_bit_in,
  input wire logic cmd_valid_in,
  output logic cmd_ready_out,
  input wire twb_pkg::twb_cmd_e cmd_op_in,
  input wire logic [7:0] cmd_data_in,
  input wire logic cmd_nack_in,
  output logic rsp_valid_out,
  output logic [7:0] rsp_data_out,
  output logic rsp_ack_out,
  output logic bus_busy_out,
  twb_if.master bus
);
  import twb_pkg::*;

  logic [1:0] scl_sync;
  logic [1:0] sda_sync;
  logic sda_prev;
  logic scl_s;
  logic sda_s;
  logic start_seen;
  logic stop_seen;
  twb_mst_e st;
  twb_slot_e slot;
  logic [15:0] cnt;
  logic [3:0] bidx;
  logic [8:0] txsh;
  logic [8:0] rxsh;
  logic scl_low;
  logic sda_low;
  logic take;
  logic half_end;

  assign scl_s = scl_sync[1];
  assign sda_s = sda_sync[1];
  assign take = cmd_valid_in & cmd_ready_out;
  assign half_end = (cnt == `TWB_HALF_LAST);
  // only low or released ever reaches the wire
  assign bus.m_scl_oe = scl_low;
  assign bus.m_sda_oe = sda_low;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      sda_prev <= 1'b1;
    end else begin
      scl_sync <= {scl_sync[0], bus.scl};
      sda_sync <= {sda_sync[0], bus.sda};
      sda_prev <= sda_s;
    end
  end

  assign start_seen = scl_s & sda_prev & ~sda_s;
  assign stop_seen = scl_s & ~sda_prev & sda_s;

  // busy is tracked from the wire, so other masters count too
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      bus_busy_out <= 1'b0;
    end else if (start_seen) begin
      bus_busy_out <= 1'b1;
    end else if (stop_seen) begin
      bus_busy_out <= 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in || serial_power_gate_bit_in) begin
      st <= TWB_M_IDLE;
      slot <= TWB_SLOT_START;
      cnt <= 16'h0000;
      bidx <= 4'h0;
      txsh <= 9'h1FF;
      rxsh <= 9'h1FF;
      scl_low <= 1'b0;
      sda_low <= 1'b0;
    end else begin
      unique case (st)
        TWB_M_IDLE: begin
          if (take && cmd_op_in == TWB_CMD_START) begin
            slot <= TWB_SLOT_START;
            txsh <= {cmd_data_in, 1'b1};
            cnt <= 16'h0000;
            st <= TWB_M_RISE;
          end
        end
        TWB_M_HOLD: begin
          if (take) begin
            cnt <= 16'h0000;
            bidx <= 4'h0;
            st <= TWB_M_LOW;
            unique case (cmd_op_in)
              TWB_CMD_START: begin
                slot <= TWB_SLOT_START;
                txsh <= {cmd_data_in, 1'b1};
              end
              TWB_CMD_WRITE: begin
                slot <= TWB_SLOT_BIT;
                txsh <= {cmd_data_in, 1'b1};
              end
              TWB_CMD_READ: begin
                slot <= TWB_SLOT_BIT;
                txsh <= {8'hFF, cmd_nack_in};
              end
              TWB_CMD_STOP: begin
                slot <= TWB_SLOT_STOP;
              end
            endcase
          end
        end
        TWB_M_LOW: begin
          cnt <= cnt + 16'h0001;
          // data moves two cycles after SCL fell, never while it is high
          if (cnt == `TWB_SDA_SET) begin
            unique case (slot)
              TWB_SLOT_START: sda_low <= 1'b0;
              TWB_SLOT_STOP: sda_low <= 1'b1;
              default: sda_low <= ~txsh[8];
            endcase
          end
          if (half_end) begin
            scl_low <= 1'b0;
            cnt <= 16'h0000;
            st <= TWB_M_RISE;
          end
        end
        TWB_M_RISE: begin
          // a stretching slave keeps us here
          if (scl_s) begin
            cnt <= 16'h0000;
            st <= TWB_M_HIGH;
          end
        end
        TWB_M_HIGH: begin
          cnt <= cnt + 16'h0001;
          if (cnt == `TWB_HALF_MID) begin
            unique case (slot)
              TWB_SLOT_START: sda_low <= 1'b1;
              TWB_SLOT_STOP: sda_low <= 1'b0;
              default: rxsh <= {rxsh[7:0], sda_s};
            endcase
          end
          if (half_end) begin
            cnt <= 16'h0000;
            unique case (slot)
              TWB_SLOT_START: begin
                slot <= TWB_SLOT_BIT;
                bidx <= 4'h0;
                scl_low <= 1'b1;
                st <= TWB_M_LOW;
              end
              TWB_SLOT_STOP: begin
                st <= TWB_M_IDLE;
              end
              default: begin
                txsh <= {txsh[7:0], 1'b1};
                bidx <= bidx + 4'h1;
                scl_low <= 1'b1;
                st <= (bidx == `TWB_BYTE_BITS) ? TWB_M_HOLD : TWB_M_LOW;
              end
            endcase
          end
        end
        default: st <= TWB_M_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cmd_ready_out <= 1'b0;
    end else begin
      // a START from idle waits for a free bus
      cmd_ready_out <= ~serial_power_gate_bit_in & ~take &
        ((st == TWB_M_IDLE & ~bus_busy_out) | st == TWB_M_HOLD);
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rsp_valid_out <= 1'b0;
      rsp_data_out <= 8'h00;
      rsp_ack_out <= 1'b0;
    end else begin
      rsp_valid_out <= 1'b0;
      if (st == TWB_M_HIGH && half_end && slot == TWB_SLOT_BIT &&
          bidx == `TWB_BYTE_BITS && !serial_power_gate_bit_in) begin
        rsp_valid_out <= 1'b1;
        rsp_data_out <= rxsh[8:1];
        rsp_ack_out <= ~rxsh[0];
      end
    end
  end
endmodule : twb_master

// ---- hw/twb_params.svh ----
// constants for the two-wire bus ends: timing counts and address codes
// assumes a 100 MHz system clock on both ends
`ifndef TWB_PARAMS_SVH
`define TWB_PARAMS_SVH
`define TWB_CLK_NS 10
`define TWB_SCL_HALF_NS 5000
`define TWB_HALF_CYC ((`TWB_SCL_HALF_NS) / (`TWB_CLK_NS))
`define TWB_HALF_LAST 16'((`TWB_HALF_CYC) - 1)
`define TWB_HALF_MID 16'((`TWB_HALF_CYC) / 2)
`define TWB_SDA_SET 16'h0001
`define TWB_GC_ADDR 7'h00
`define TWB_RSV_HI 4'hF
`define TWB_BYTE_BITS 4'h8
`define TWB_FIFO_DEPTH 16
`define TWB_BYTE_W 8
`endif

// ---- hw/twb_pkg.sv ----
// types shared by both ends of the two-wire bus
// no assumptions beyond a SystemVerilog toolchain
package twb_pkg;
  typedef enum logic [1:0] {
    TWB_CMD_START = 2'h0,
    TWB_CMD_WRITE = 2'h1,
    TWB_CMD_READ = 2'h2,
    TWB_CMD_STOP = 2'h3
  } twb_cmd_e;
  typedef enum logic [1:0] {
    TWB_SLOT_START = 2'h0,
    TWB_SLOT_BIT = 2'h1,
    TWB_SLOT_STOP = 2'h2
  } twb_slot_e;
  typedef enum logic [2:0] {
    TWB_M_IDLE = 3'h0,
    TWB_M_RISE = 3'h1,
    TWB_M_HIGH = 3'h3,
    TWB_M_LOW = 3'h2,
    TWB_M_HOLD = 3'h6
  } twb_mst_e;
  typedef enum logic [3:0] {
    TWB_S_IDLE = 4'h0,
    TWB_S_ADDR = 4'h1,
    TWB_S_ADDR_ACK = 4'h3,
    TWB_S_RX = 4'h2,
    TWB_S_RX_PUSH = 4'h6,
    TWB_S_RX_ACK = 4'h7,
    TWB_S_TX_LOAD = 4'h5,
    TWB_S_TX = 4'h4,
    TWB_S_TX_ACK = 4'hC,
    TWB_S_WAIT = 4'hD
  } twb_slv_e;
endpackage : twb_pkg

// ---- hw/twb_slave.sv ----
// far end: two-wire bus slave, received bytes leave through a fifo
// bus pins come from another domain and are synchronised here
`timescale 1ns/100ps
`include "twb_params.svh"
module twb_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;

  assign in_ready_out = (count != (AW + 1)'(DEPTH));
  assign out_valid_out = (count != '0);
  assign out_data_out = mem[rd_ptr];
  assign push = in_valid_in & in_ready_out;
  assign pop = out_valid_out & out_ready_in;

  always_ff @(posedge clk_in) begin
    if (push) begin
      mem[wr_ptr] <= in_data_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (AW + 1)'(push) - (AW + 1)'(pop);
    end
  end
endmodule : twb_fifo

module twb_slave (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [6:0] own_addr_in,
  input wire logic gc_enable_in,
  input wire logic rx_accept_in,
  output logic rx_valid_out,
  input wire logic rx_ready_in,
  output logic [7:0] rx_data_out,
  input wire logic tx_valid_in,
  input wire logic [7:0] tx_data_in,
  output logic tx_taken_out,
  output logic gc_hit_out,
  twb_if.slave bus
);
  import twb_pkg::*;

  logic [1:0] scl_sync;
  logic [1:0] sda_sync;
  logic scl_prev;
  logic sda_prev;
  logic scl_s;
  logic sda_s;
  logic rise;
  logic fall;
  logic start_seen;
  logic stop_seen;
  twb_slv_e st;
  logic [3:0] cnt;
  logic [7:0] sh;
  logic scl_low;
  logic sda_low;
  logic nacked;
  logic push;
  logic fifo_ready;

  // zero is general call, 1111xxx reserved: never an own address
  function automatic logic addr_legal(input logic [6:0] a);
    addr_legal = (a != `TWB_GC_ADDR) && (a[6:3] != `TWB_RSV_HI);
  endfunction : addr_legal

  assign scl_s = scl_sync[1];
  assign sda_s = sda_sync[1];
  assign rise = scl_s & ~scl_prev;
  assign fall = ~scl_s & scl_prev;
  assign start_seen = scl_s & sda_prev & ~sda_s;
  assign stop_seen = scl_s & ~sda_prev & sda_s;
  assign bus.s_scl_oe = scl_low;
  assign bus.s_sda_oe = sda_low;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
    end else begin
      scl_sync <= {scl_sync[0], bus.scl};
      sda_sync <= {sda_sync[0], bus.sda};
      scl_prev <= scl_s;
      sda_prev <= sda_s;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      st <= TWB_S_IDLE;
      cnt <= 4'h0;
      sh <= 8'h00;
      scl_low <= 1'b0;
      sda_low <= 1'b0;
      nacked <= 1'b0;
      push <= 1'b0;
      tx_taken_out <= 1'b0;
      gc_hit_out <= 1'b0;
    end else if (start_seen) begin
      st <= TWB_S_ADDR;
      cnt <= 4'h0;
      scl_low <= 1'b0;
      sda_low <= 1'b0;
      push <= 1'b0;
      tx_taken_out <= 1'b0;
    end else if (stop_seen) begin
      st <= TWB_S_IDLE;
      scl_low <= 1'b0;
      sda_low <= 1'b0;
      push <= 1'b0;
      tx_taken_out <= 1'b0;
    end else begin
      push <= 1'b0;
      tx_taken_out <= 1'b0;
      unique case (st)
        TWB_S_IDLE, TWB_S_WAIT: begin
          sda_low <= 1'b0;
        end
        TWB_S_ADDR: begin
          if (rise) begin
            sh <= {sh[6:0], sda_s};
            cnt <= cnt + 4'h1;
          end
          if (fall && cnt == `TWB_BYTE_BITS) begin
            if (sh[7:1] == own_addr_in && addr_legal(own_addr_in)) begin
              sda_low <= 1'b1;
              gc_hit_out <= 1'b0;
              st <= TWB_S_ADDR_ACK;
            end else if (sh[7:1] == `TWB_GC_ADDR && !sh[0] &&
                         gc_enable_in) begin
              sda_low <= 1'b1;
              gc_hit_out <= 1'b1;
              st <= TWB_S_ADDR_ACK;
            end else begin
              st <= TWB_S_WAIT;
            end
          end
        end
        TWB_S_ADDR_ACK: begin
          if (fall) begin
            sda_low <= 1'b0;
            cnt <= 4'h0;
            st <= sh[0] ? TWB_S_TX_LOAD : TWB_S_RX;
          end
        end
        TWB_S_TX_LOAD: begin
          // no byte ready: hold SCL low until one arrives
          if (tx_valid_in) begin
            sh <= tx_data_in;
            sda_low <= ~tx_data_in[7];
            tx_taken_out <= 1'b1;
            cnt <= 4'h0;
            st <= TWB_S_TX;
          end else begin
            scl_low <= 1'b1;
          end
        end
        TWB_S_TX: begin
          // released a cycle after the first bit is set up, not with it
          scl_low <= 1'b0;
          if (rise) begin
            cnt <= cnt + 4'h1;
          end
          if (fall) begin
            if (cnt == `TWB_BYTE_BITS) begin
              sda_low <= 1'b0;
              st <= TWB_S_TX_ACK;
            end else begin
              sh <= {sh[6:0], 1'b1};
              sda_low <= ~sh[6];
            end
          end
        end
        TWB_S_TX_ACK: begin
          if (rise) begin
            nacked <= sda_s;
          end
          if (fall) begin
            st <= nacked ? TWB_S_WAIT : TWB_S_TX_LOAD;
          end
        end
        TWB_S_RX: begin
          if (rise) begin
            sh <= {sh[6:0], sda_s};
            cnt <= cnt + 4'h1;
          end
          if (fall && cnt == `TWB_BYTE_BITS) begin
            st <= TWB_S_RX_PUSH;
          end
        end
        TWB_S_RX_PUSH: begin
          // a full fifo stretches the clock rather than losing a byte
          if (!rx_accept_in) begin
            nacked <= 1'b1;
            st <= TWB_S_RX_ACK;
          end else if (fifo_ready) begin
            push <= 1'b1;
            nacked <= 1'b0;
            sda_low <= 1'b1;
            st <= TWB_S_RX_ACK;
          end else begin
            scl_low <= 1'b1;
          end
        end
        TWB_S_RX_ACK: begin
          // ack level is on the wire before a stretch ends
          scl_low <= 1'b0;
          if (fall) begin
            sda_low <= 1'b0;
            cnt <= 4'h0;
            st <= nacked ? TWB_S_WAIT : TWB_S_RX;
          end
        end
        default: st <= TWB_S_IDLE;
      endcase
    end
  end

  twb_fifo #(
    .WIDTH(`TWB_BYTE_W),
    .DEPTH(`TWB_FIFO_DEPTH)
  ) u_rx_fifo (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .in_valid_in(push),
    .in_ready_out(fifo_ready),
    .in_data_in(sh),
    .out_valid_out(rx_valid_out),
    .out_ready_in(rx_ready_in),
    .out_data_out(rx_data_out)
  );
endmodule : twb_slave

// ---- tb/testbench.sv ----
// self-checking bench joining the master and slave ends over one bus
// assumes both ends share this bench's clock and synchronous reset
`timescale 1ns/100ps
module testbench;
  import twb_pkg::*;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic gate = 1'b0;
  logic cmd_valid = 1'b0;
  logic cmd_nack = 1'b0;
  logic [7:0] cmd_data = 8'h00;
  twb_cmd_e cmd_op = TWB_CMD_START;
  logic cmd_ready, rsp_valid, rsp_ack, busy, rx_valid, tx_taken, gc_hit;
  logic [7:0] rsp_data, rx_data;
  logic gc_en = 1'b0;
  logic [6:0] own_addr = 7'h50;
  logic rx_accept = 1'b1;
  logic rx_ready = 1'b0;
  logic tx_valid = 1'b0;
  logic [7:0] tx_data = 8'h00;
  int bad_count = 0;
  int checks_done = 0;
  always #5 clk_in = ~clk_in;
  twb_if bus ();
  twb_master i_twb_master (.clk_in(clk_in), .rst_in(rst_in),
    .serial_power_gate_bit_in(gate), .cmd_valid_in(cmd_valid),
    .cmd_ready_out(cmd_ready), .cmd_op_in(cmd_op), .cmd_data_in(cmd_data),
    .cmd_nack_in(cmd_nack), .rsp_valid_out(rsp_valid),
    .rsp_data_out(rsp_data), .rsp_ack_out(rsp_ack),
    .bus_busy_out(busy), .bus(bus));
  twb_slave i_twb_slave (.clk_in(clk_in), .rst_in(rst_in),
    .own_addr_in(own_addr), .gc_enable_in(gc_en), .rx_accept_in(rx_accept),
    .rx_valid_out(rx_valid), .rx_ready_in(rx_ready), .rx_data_out(rx_data),
    .tx_valid_in(tx_valid), .tx_data_in(tx_data), .tx_taken_out(tx_taken),
    .gc_hit_out(gc_hit), .bus(bus));
  twb_chk i_twb_chk (.clk_in(clk_in), .rst_in(rst_in),
    .m_scl_oe(bus.m_scl_oe), .m_sda_oe(bus.m_sda_oe),
    .s_scl_oe(bus.s_scl_oe), .s_sda_oe(bus.s_sda_oe),
    .scl(bus.scl), .sda(bus.sda));
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : stop_test
  task automatic chk(input string what, input logic [7:0] seen,
      input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // 0 ready, 1 response pulse, 2 transmit byte taken; pulses seen at negedge
  task automatic wait_sig(input int which, input int lim);
    int n;
    for (n = 0; n < lim; n++) begin
      @(negedge clk_in);
      if ((which == 0 && cmd_ready === 1'b1) ||
          (which == 1 && rsp_valid === 1'b1) ||
          (which == 2 && tx_taken === 1'b1)) break;
    end
    if (n == lim) begin
      bad_count++;
      $display("BAD wait %0d expected 1 seen 0", which);
      stop_test();
    end
  endtask : wait_sig
  task automatic send(input twb_cmd_e op, input logic [7:0] d,
      input logic nk);
    wait_sig(0, 20000);
    cmd_op = op;
    cmd_data = d;
    cmd_nack = nk;
    cmd_valid = 1'b1;
    @(negedge clk_in);
    cmd_valid = 1'b0;
  endtask : send
  task automatic pkt(input twb_cmd_e op, input logic [7:0] d,
      input logic ack, input logic [7:0] rd);
    send(op, d, 1'b0);
    wait_sig(1, 20000);
    chk("rsp_ack", 8'(rsp_ack), 8'(ack));
    chk("rsp_data", rsp_data, rd);
  endtask : pkt
  task automatic end_frame;
    send(TWB_CMD_STOP, 8'h00, 1'b0);
    wait_sig(0, 20000);
    chk("busy", 8'(busy), 8'h00);
    chk("scl", 8'(bus.scl), 8'h01);
    chk("sda", 8'(bus.sda), 8'h01);
  endtask : end_frame
  task automatic t_write;
    chk("idle_busy", 8'(busy), 8'h00);
    pkt(TWB_CMD_START, 8'hA0, 1'b1, 8'hA0);
    chk("busy", 8'(busy), 8'h01);
    pkt(TWB_CMD_WRITE, 8'hA5, 1'b1, 8'hA5);
    chk("rx_valid", 8'(rx_valid), 8'h01);
    chk("rx_data", rx_data, 8'hA5);
    rx_ready = 1'b1;
    @(negedge clk_in);
    rx_ready = 1'b0;
    chk("rx_empty", 8'(rx_valid), 8'h00);
    end_frame();
    $display("test write done");
  endtask : t_write
  task automatic t_restart;
    // a reserved address must never match, even if strapped as own
    own_addr = 7'h79;
    pkt(TWB_CMD_START, 8'hF2, 1'b0, 8'hF2);
    own_addr = 7'h50;
    pkt(TWB_CMD_START, 8'hA1, 1'b1, 8'hA1);
    chk("busy", 8'(busy), 8'h01);
    tx_data = 8'h3C;
    send(TWB_CMD_READ, 8'hFF, 1'b1);
    // no byte offered yet, so only the slave can be holding the clock
    repeat (2000) @(negedge clk_in);
    chk("stretch", 8'(bus.scl), 8'h00);
    chk("mst_rel", 8'(bus.m_scl_oe), 8'h00);
    tx_valid = 1'b1;
    wait_sig(2, 200);
    tx_valid = 1'b0;
    wait_sig(1, 20000);
    chk("rd_data", rsp_data, 8'h3C);
    chk("rd_ack", 8'(rsp_ack), 8'h00);
    end_frame();
    $display("test restart done");
  endtask : t_restart
  task automatic t_gcall;
    gc_en = 1'b1;
    pkt(TWB_CMD_START, 8'h00, 1'b1, 8'h00);
    chk("gc_hit", 8'(gc_hit), 8'h01);
    rx_accept = 1'b0;
    pkt(TWB_CMD_WRITE, 8'h5A, 1'b0, 8'h5A);
    chk("dropped", 8'(rx_valid), 8'h00);
    rx_accept = 1'b1;
    end_frame();
    gc_en = 1'b0;
    // zero strapped as own address must not turn into a match
    own_addr = 7'h00;
    pkt(TWB_CMD_START, 8'h00, 1'b0, 8'h00);
    end_frame();
    own_addr = 7'h50;
    $display("test gcall done");
  endtask : t_gcall
  task automatic t_gate;
    gate = 1'b1;
    cmd_op = TWB_CMD_START;
    cmd_data = 8'hA0;
    cmd_valid = 1'b1;
    repeat (50) @(negedge clk_in);
    chk("gate_ready", 8'(cmd_ready), 8'h00);
    chk("gate_sda", 8'(bus.sda), 8'h01);
    gate = 1'b0;
    cmd_valid = 1'b0;
    wait_sig(0, 200);
    chk("gate_busy", 8'(busy), 8'h00);
    $display("test gate done");
  endtask : t_gate
  initial begin
    repeat (2) @(negedge clk_in);
    rst_in = 1'b0;
    t_write();
    t_restart();
    t_gcall();
    t_gate();
    stop_test();
  end
endmodule : testbench

// ---- tb/twb_chk.sv ----
// concurrent checks on the shared two-wire bus between master and slave
// assumes the bench clock and active-high synchronous reset of both ends
`timescale 1ns/100ps
module twb_chk (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic m_scl_oe,
  input wire logic m_sda_oe,
  input wire logic s_scl_oe,
  input wire logic s_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  // well under the 500-cycle high phase, above any sync slack
  localparam int HIGH_MIN = 400;
  logic pscl;
  logic psda;
  logic in_frame;
  logic [7:0] bits;
  logic [9:0] hi_cnt;
  logic ev_start;
  logic ev_stop;
  assign ev_start = scl && pscl && psda && !sda;
  assign ev_stop = scl && pscl && !psda && sda;
  always_ff @(posedge clk_in) begin
    pscl <= rst_in | scl;
    psda <= rst_in | sda;
  end
  always_ff @(posedge clk_in) begin
    if (rst_in || ev_stop) begin
      in_frame <= 1'b0;
    end else if (ev_start) begin
      in_frame <= 1'b1;
    end
  end
  // rising clock edges since the last start condition
  always_ff @(posedge clk_in) begin
    if (rst_in || ev_start) begin
      bits <= 8'h00;
    end else if (scl && !pscl) begin
      bits <= bits + 8'h01;
    end
  end
  // saturates so a long idle bus cannot wrap back below the limit
  always_ff @(posedge clk_in) begin
    if (rst_in || !scl) begin
      hi_cnt <= 10'h000;
    end else if (hi_cnt != 10'h3FF) begin
      hi_cnt <= hi_cnt + 10'h001;
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // also catches data that moves on the very edge a stretch is released
  property p_sda_steady; scl |-> $stable(s_sda_oe); endproperty
  a_sda_steady: assert property (p_sda_steady)
    else $error("slave data moved while clock high");
  property p_mst_sda_steady;
    scl && !ev_start && !ev_stop |-> $stable(m_sda_oe);
  endproperty
  a_mst_sda_steady: assert property (p_mst_sda_steady)
    else $error("master data moved while clock high");
  property p_start_drv; ev_start |-> $rose(m_sda_oe); endproperty
  a_start_drv: assert property (p_start_drv)
    else $error("start edge not made by master pulling data");
  property p_stop_drv; ev_stop |-> $fell(m_sda_oe); endproperty
  a_stop_drv: assert property (p_stop_drv)
    else $error("stop edge not made by master releasing data");
  property p_stretch_low; $rose(s_scl_oe) |-> !pscl; endproperty
  a_stretch_low: assert property (p_stretch_low)
    else $error("slave cut a clock high phase");
  property p_high_min; $rose(m_scl_oe) |-> hi_cnt >= HIGH_MIN; endproperty
  a_high_min: assert property (p_high_min)
    else $error("clock high phase too short");
  property p_low_min; $rose(m_scl_oe) |=> m_scl_oe [*8]; endproperty
  a_low_min: assert property (p_low_min)
    else $error("clock low phase too short");
  property p_frame_bits;
    (ev_start || ev_stop) && in_frame |-> bits % 8'h09 == 8'h01;
  endproperty
  a_frame_bits: assert property (p_frame_bits)
    else $error("packet not nine clocks long");
  property p_nonempty; ev_stop && in_frame |-> bits >= 8'h0A; endproperty
  a_nonempty: assert property (p_nonempty)
    else $error("stop before any packet");
  property p_stop_free;
    ev_stop |=> !s_scl_oe && !s_sda_oe && !m_scl_oe;
  endproperty
  a_stop_free: assert property (p_stop_free)
    else $error("line still pulled after stop");
endmodule : twb_chk
